// File: design/serial_break_and_baud_control.sv
// Function
// - on break detect set break flag, framing error and receive full
// - in 9-bit mode a break clears the received ninth bit
// - break flag: no interrupt, cleared by status two read then data read, reset clears
// - break flag rearms only after the line shows ones and a new break arrives
// - receive active flag sets on a zero at first start-search sample, no interrupt
// - receive active flag clears on false start or idle character
// - data reads return received byte, data writes give the byte to transmit
// - reset does not touch the data buffer contents
// - one baud rate from both baud registers clocks receiver and transmitter
// - lin rx bit alone: break detect needs 13 or 14 bits
// - lin tx bit alone: generated break is 13 or 14 bits
// - both lin bits: detect 13/14, generate 11/12 bits
// - lengthened detect threshold filters stretched all-zero characters
// - prescale field codes 0..3 divide by 1, 3, 4, 13; reset clears
// - rate select field divides by two to the field value; reset clears
// - prescaler divide field: 0 bypasses, 1..7 divide by 2..8; reset clears
// - baud equals clock over 64 times all divisors with fine adjust
// - insertion field adds that many clocks per 32 prescaler outputs
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "serial_break_and_baud_control_params.svh"
module serial_break_and_baud_control
(
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  // axi4-lite write address and data
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // serial line
  input  wire logic        rxd_i,
  output logic             txd_o
);

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  logic [7:0]  baud_rate_control;
  logic [7:0]  baud_prescaler_control;
  logic [7:0]  serial_control;
  logic [7:0]  serial_data_buffer;
  logic [7:0]  tx_buffer;
  logic        break_seen_flag;
  logic        receive_active_flag;
  logic        framing_error_flag;
  logic        receive_full_flag;
  logic        ninth_rx_bit;
  logic        tx_empty;
  logic        brk_clear_armed;
  logic        s1_clear_armed;
  logic        break_armed;
  logic        rx_meta;
  logic        rx_sync;
  serial_break_and_baud_control_pkg::rx_state_e rx_state;
  serial_break_and_baud_control_pkg::tx_state_e tx_state;

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  wire       lin_tx_break_len_enable    = baud_rate_control[`BIT_LIN_TX];
  wire       lin_rx_break_filter_enable = baud_rate_control[`BIT_LIN_RX];
  wire [1:0] baud_prescale_select       = baud_rate_control[4:3];
  wire [2:0] baud_rate_select           = baud_rate_control[2:0];
  wire [2:0] prescaler_divide_select    = baud_prescaler_control[7:5];
  wire [4:0] clock_insertion_select     = baud_prescaler_control[4:0];
  wire       serial_module_enable       = serial_control[`BIT_ENABLE];
  wire       nine_bit                   = serial_control[`BIT_NINE_BIT];
  wire       send_break                 = serial_control[`BIT_SEND_BREAK];
  wire       ninth_tx_bit               = serial_control[`BIT_NINTH_TX];

  // ----------------------------------------------------------------
  // baud chain: fine prescaler, register prescaler, rate divider, /4
  // ----------------------------------------------------------------
  logic [3:0] pre_cnt;
  logic [4:0] frac_acc;
  logic       stretch;
  logic [3:0] bpd_cnt;
  logic [6:0] bd_cnt;
  logic [1:0] q_cnt;

  // bypass is divide by one, stretched periods add the fraction
  wire [3:0] fine_prescaler_divisor = (prescaler_divide_select == 3'h0) ? 4'h1 :
                                      {1'b0, prescaler_divide_select} + 4'h1;
  wire [3:0] pre_last      = fine_prescaler_divisor + {3'h0, stretch} - 4'h1;
  wire       pre_tick      = serial_module_enable && (pre_cnt == pre_last);
  wire [5:0] frac_sum      = {1'b0, frac_acc} + {1'b0, clock_insertion_select};
  wire [3:0] baud_register_prescale = (baud_prescale_select == 2'h0) ? 4'h1 :
                                      (baud_prescale_select == 2'h1) ? 4'h3 :
                                      (baud_prescale_select == 2'h2) ? 4'h4 : 4'hd;
  wire       bpd_tick      = pre_tick && (bpd_cnt == baud_register_prescale - 4'h1);
  wire [7:0] baud_divider  = 8'h01 << baud_rate_select;
  wire       bd_tick       = bpd_tick && ({1'b0, bd_cnt} == baud_divider - 8'h01);
  wire       rt_tick       = bd_tick && (q_cnt == `RT_PER_QUARTER);

  // divider counters; the carry of the fraction accumulator picks stretched periods
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pre_cnt  <= 4'h0;
      frac_acc <= 5'h00;
      stretch  <= 1'b0;
      bpd_cnt  <= 4'h0;
      bd_cnt   <= 7'h00;
      q_cnt    <= 2'h0;
    end
    else if (!serial_module_enable)
    begin
      pre_cnt  <= 4'h0;
      frac_acc <= 5'h00;
      stretch  <= 1'b0;
      bpd_cnt  <= 4'h0;
      bd_cnt   <= 7'h00;
      q_cnt    <= 2'h0;
    end
    else
    begin
      pre_cnt <= pre_tick ? 4'h0 : pre_cnt + 4'h1;
      if (pre_tick)
      begin
        frac_acc <= frac_sum[4:0];
        stretch  <= frac_sum[5];
        bpd_cnt  <= bpd_tick ? 4'h0 : bpd_cnt + 4'h1;
      end
      if (bpd_tick)
        bd_cnt <= bd_tick ? 7'h00 : bd_cnt + 7'h01;
      if (bd_tick)
        q_cnt <= q_cnt + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  wire wr_take = s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_bvalid_o;
  wire rd_take = s_axi_arvalid_i && !s_axi_rvalid_o;
  wire wr_hit  = (s_axi_awaddr_i == `OFS_DATA_BUFFER) || (s_axi_awaddr_i == `OFS_BAUD_RATE) ||
                 (s_axi_awaddr_i == `OFS_BAUD_PRESCALER) || (s_axi_awaddr_i == `OFS_SERIAL_CONTROL);
  wire wr_en   = wr_take && s_axi_wstrb_i[0];
  wire wr_data = wr_en && (s_axi_awaddr_i == `OFS_DATA_BUFFER);
  wire rd_s1   = rd_take && (s_axi_araddr_i == `OFS_STATUS_ONE);
  wire rd_s2   = rd_take && (s_axi_araddr_i == `OFS_STATUS_TWO);
  wire rd_data = rd_take && (s_axi_araddr_i == `OFS_DATA_BUFFER);

  wire [7:0] status_one = {tx_empty, 1'b0, receive_full_flag, 3'h0, framing_error_flag, ninth_rx_bit};
  // break flag and active flag only: neither drives any request line
  wire [7:0] serial_status_two = {6'h00, break_seen_flag, receive_active_flag};

  // read mux; unmapped reads return zero with an error response
  wire [7:0] rd_mux = (s_axi_araddr_i == `OFS_STATUS_ONE)     ? status_one :
                      (s_axi_araddr_i == `OFS_STATUS_TWO)     ? serial_status_two :
                      (s_axi_araddr_i == `OFS_DATA_BUFFER)    ? serial_data_buffer :
                      (s_axi_araddr_i == `OFS_BAUD_RATE)      ? baud_rate_control :
                      (s_axi_araddr_i == `OFS_BAUD_PRESCALER) ? baud_prescaler_control :
                      (s_axi_araddr_i == `OFS_SERIAL_CONTROL) ? serial_control : 8'h00;
  wire rd_hit = (s_axi_araddr_i == `OFS_STATUS_ONE) || (s_axi_araddr_i == `OFS_STATUS_TWO) ||
                (s_axi_araddr_i == `OFS_DATA_BUFFER) || (s_axi_araddr_i == `OFS_BAUD_RATE) ||
                (s_axi_araddr_i == `OFS_BAUD_PRESCALER) || (s_axi_araddr_i == `OFS_SERIAL_CONTROL);

  assign s_axi_awready_o = wr_take;
  assign s_axi_wready_o  = wr_take;
  assign s_axi_arready_o = !s_axi_rvalid_o;

  // response channels and control registers
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      s_axi_bvalid_o         <= 1'b0;
      s_axi_bresp_o          <= `RESP_OKAY;
      s_axi_rvalid_o         <= 1'b0;
      s_axi_rresp_o          <= `RESP_OKAY;
      s_axi_rdata_o          <= 32'h00000000;
      baud_rate_control      <= `RST_BAUD_RATE;
      baud_prescaler_control <= `RST_BAUD_PRESCALER;
      serial_control         <= `RST_SERIAL_CONTROL;
    end
    else
    begin
      if (wr_take)
      begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bready_i)
        s_axi_bvalid_o <= 1'b0;
      if (rd_take)
      begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        s_axi_rdata_o  <= {24'h000000, rd_mux};
      end
      else if (s_axi_rready_i)
        s_axi_rvalid_o <= 1'b0;
      if (wr_en && (s_axi_awaddr_i == `OFS_BAUD_RATE))
        baud_rate_control <= {1'b0, s_axi_wdata_i[6:0]};
      if (wr_en && (s_axi_awaddr_i == `OFS_BAUD_PRESCALER))
        baud_prescaler_control <= s_axi_wdata_i[7:0];
      if (wr_en && (s_axi_awaddr_i == `OFS_SERIAL_CONTROL))
        serial_control <= {4'h0, s_axi_wdata_i[3:0]};
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  logic [3:0] rx_rt;
  logic [3:0] rx_bits;
  logic [3:0] zero_bits;
  logic [8:0] rx_shift;
  logic       all_zero;
  logic [7:0] ones_rt;
  logic       brk_event;
  logic       rx_load;

  wire       mid       = rt_tick && (rx_rt == `RT_MID_BIT);
  wire [3:0] data_bits = nine_bit ? 4'h9 : 4'h8;
  wire [3:0] brk_det   = nine_bit ? `BRK_DET_LIN_9 : `BRK_DET_LIN_8;
  wire [7:0] idle_rt   = nine_bit ? `IDLE_RT_9 : `IDLE_RT_8;
  wire       rt1_zero  = rt_tick && (rx_state == serial_break_and_baud_control_pkg::RX_IDLE) && !rx_sync;
  wire       false_st  = mid && (rx_state == serial_break_and_baud_control_pkg::RX_START) && rx_sync;
  wire       idle_seen = rt_tick && (rx_state == serial_break_and_baud_control_pkg::RX_IDLE) &&
                         rx_sync && (ones_rt == idle_rt - 8'h01);
  wire       stop_mid  = mid && (rx_state == serial_break_and_baud_control_pkg::RX_STOP);
  wire       brk_cand  = stop_mid && !rx_sync && all_zero;
  wire       brk_lin   = mid && (rx_state == serial_break_and_baud_control_pkg::RX_BRK) &&
                         !rx_sync && (zero_bits == brk_det - 4'h1);

  // the line pin crosses into this clock through two flops
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end
    else
    begin
      rx_meta <= rxd_i;
      rx_sync <= rx_meta;
    end
  end

  // a detected break is held back unless the line has shown ones since the last one
  always_comb
  begin
    brk_event = 1'b0;
    if (brk_cand && !lin_rx_break_filter_enable)
      brk_event = break_armed;
    if (brk_lin)
      brk_event = break_armed;
    rx_load = stop_mid;
  end

  // receive sequencer; all sampling is on the shared baud sample tick
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rx_state  <= serial_break_and_baud_control_pkg::RX_IDLE;
      rx_rt     <= 4'h0;
      rx_bits   <= 4'h0;
      zero_bits <= 4'h0;
      rx_shift  <= 9'h000;
      all_zero  <= 1'b0;
      ones_rt   <= 8'h00;
    end
    else if (rt_tick)
    begin
      rx_rt <= (rx_state == serial_break_and_baud_control_pkg::RX_IDLE) ? 4'h1 : rx_rt + 4'h1;
      case (rx_state)
        serial_break_and_baud_control_pkg::RX_IDLE:
        begin
          ones_rt <= (!rx_sync || idle_seen) ? 8'h00 : ones_rt + 8'h01;
          if (!rx_sync)
            rx_state <= serial_break_and_baud_control_pkg::RX_START;
        end
        serial_break_and_baud_control_pkg::RX_START:
          if (mid)
          begin
            rx_state <= rx_sync ? serial_break_and_baud_control_pkg::RX_IDLE :
                                  serial_break_and_baud_control_pkg::RX_DATA;
            rx_bits  <= 4'h0;
            all_zero <= 1'b1;
          end
        serial_break_and_baud_control_pkg::RX_DATA:
          if (mid)
          begin
            rx_shift <= nine_bit ? {rx_sync, rx_shift[8:1]} : {1'b0, rx_sync, rx_shift[7:1]};
            all_zero <= all_zero && !rx_sync;
            rx_bits  <= rx_bits + 4'h1;
            if (rx_bits == data_bits - 4'h1)
              rx_state <= serial_break_and_baud_control_pkg::RX_STOP;
          end
        serial_break_and_baud_control_pkg::RX_STOP:
          if (mid)
          begin
            zero_bits <= data_bits + 4'h2;
            ones_rt   <= 8'h00;
            rx_state  <= (brk_cand && lin_rx_break_filter_enable) ?
                         serial_break_and_baud_control_pkg::RX_BRK :
                         serial_break_and_baud_control_pkg::RX_IDLE;
          end
        serial_break_and_baud_control_pkg::RX_BRK:
          if (mid)
          begin
            zero_bits <= zero_bits + 4'h1;
            if (rx_sync || brk_lin)
              rx_state <= serial_break_and_baud_control_pkg::RX_IDLE;
          end
        default:
          rx_state <= serial_break_and_baud_control_pkg::RX_IDLE;
      endcase
    end
  end

  // received byte; data buffers keep their contents through reset
  always_ff @(posedge clk_sys_i)
  begin
    if (rx_load)
      serial_data_buffer <= rx_shift[7:0];
    if (wr_data)
      tx_buffer <= s_axi_wdata_i[7:0];
  end

  // status flags; a set in the same cycle as a clear wins
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      break_seen_flag     <= 1'b0;
      receive_active_flag <= 1'b0;
      framing_error_flag  <= 1'b0;
      receive_full_flag   <= 1'b0;
      ninth_rx_bit        <= 1'b0;
      brk_clear_armed     <= 1'b0;
      s1_clear_armed      <= 1'b0;
      break_armed         <= 1'b1;
    end
    else
    begin
      if (rd_s2)
        brk_clear_armed <= break_seen_flag;
      else if (rd_data)
        brk_clear_armed <= 1'b0;
      if (rd_s1)
        s1_clear_armed <= framing_error_flag || receive_full_flag;
      else if (rd_data)
        s1_clear_armed <= 1'b0;
      if (brk_event)
        break_seen_flag <= 1'b1;
      else if (rd_data && brk_clear_armed)
        break_seen_flag <= 1'b0;
      if (rt1_zero)
        receive_active_flag <= 1'b1;
      else if (false_st || idle_seen)
        receive_active_flag <= 1'b0;
      if (brk_event || (stop_mid && !rx_sync))
        framing_error_flag <= 1'b1;
      else if (rd_data && s1_clear_armed)
        framing_error_flag <= 1'b0;
      if (brk_event || rx_load)
        receive_full_flag <= 1'b1;
      else if (rd_data && s1_clear_armed)
        receive_full_flag <= 1'b0;
      if (brk_event)
        ninth_rx_bit <= 1'b0;
      else if (rx_load)
        ninth_rx_bit <= nine_bit ? rx_shift[8] : rx_shift[7]; // 8-bit mode mirrors data bit 7
      if (brk_event)
        break_armed <= 1'b0;
      else if (rt_tick && rx_sync && (rx_state == serial_break_and_baud_control_pkg::RX_IDLE))
        break_armed <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  logic [3:0]  tx_rt;
  logic [3:0]  tx_left;
  logic [10:0] tx_shift;

  wire       tx_bit   = rt_tick && (tx_rt == `RT_PER_BIT);
  wire [3:0] brk_gen  = (lin_tx_break_len_enable && lin_rx_break_filter_enable) ?
                        (nine_bit ? `BRK_GEN_BOTH_9 : `BRK_GEN_BOTH_8) :
                        lin_tx_break_len_enable ?
                        (nine_bit ? `BRK_GEN_LIN_9 : `BRK_GEN_LIN_8) :
                        (nine_bit ? `BRK_GEN_NORM_9 : `BRK_GEN_NORM_8);
  wire [10:0] tx_frame = nine_bit ? {1'b1, ninth_tx_bit, tx_buffer, 1'b0} : {2'b11, tx_buffer, 1'b0};

  // frames start on bit boundaries of the shared baud clock
  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      tx_state <= serial_break_and_baud_control_pkg::TX_IDLE;
      tx_rt    <= 4'h0;
      tx_left  <= 4'h0;
      tx_shift <= 11'h7ff;
      tx_empty <= 1'b1;
      txd_o    <= 1'b1;
    end
    else
    begin
      if (wr_data)
        tx_empty <= 1'b0;
      if (rt_tick)
        tx_rt <= tx_rt + 4'h1;
      if (tx_bit)
      begin
        case (tx_state)
          serial_break_and_baud_control_pkg::TX_IDLE:
            if (send_break)
            begin
              tx_state <= serial_break_and_baud_control_pkg::TX_BRK;
              tx_left  <= brk_gen - 4'h1;
              txd_o    <= 1'b0;
            end
            else if (!tx_empty && !wr_data)
            begin
              tx_state <= serial_break_and_baud_control_pkg::TX_SHIFT;
              tx_shift <= {1'b1, tx_frame[10:1]};
              tx_left  <= data_bits + 4'h1;
              tx_empty <= 1'b1;
              txd_o    <= 1'b0;
            end
            else
              txd_o <= 1'b1;
          serial_break_and_baud_control_pkg::TX_SHIFT:
          begin
            txd_o    <= tx_shift[0];
            tx_shift <= {1'b1, tx_shift[10:1]};
            tx_left  <= tx_left - 4'h1;
            if (tx_left == 4'h0)
              tx_state <= serial_break_and_baud_control_pkg::TX_IDLE;
          end
          serial_break_and_baud_control_pkg::TX_BRK:
          begin
            tx_left <= tx_left - 4'h1;
            if (tx_left == 4'h1 && !send_break)
            begin
              tx_state <= serial_break_and_baud_control_pkg::TX_SHIFT;
              tx_shift <= 11'h7ff;
              tx_left  <= 4'h0;
            end
            else if (tx_left == 4'h1)
              tx_left <= brk_gen;
            txd_o <= 1'b0;
          end
          default:
            tx_state <= serial_break_and_baud_control_pkg::TX_IDLE;
        endcase
      end
    end
  end

endmodule

// File: design/serial_break_and_baud_control_params.svh
`ifndef SERIAL_BREAK_AND_BAUD_CONTROL_PARAMS_SVH
`define SERIAL_BREAK_AND_BAUD_CONTROL_PARAMS_SVH
// register byte offsets
`define OFS_STATUS_ONE      8'h10
`define OFS_STATUS_TWO      8'h14
`define OFS_DATA_BUFFER     8'h18
`define OFS_BAUD_RATE       8'h1c
`define OFS_BAUD_PRESCALER  8'h20
`define OFS_SERIAL_CONTROL  8'h24
// field positions
`define BIT_TX_EMPTY        7
`define BIT_RX_FULL         5
`define BIT_FRAMING_ERROR   1
`define BIT_NINTH_RX        0
`define BIT_BREAK_SEEN      1
`define BIT_RX_ACTIVE       0
`define BIT_LIN_TX          6
`define BIT_LIN_RX          5
`define BIT_ENABLE          0
`define BIT_NINE_BIT        1
`define BIT_SEND_BREAK      2
`define BIT_NINTH_TX        3
// reset values
`define RST_BAUD_RATE       8'h00
`define RST_BAUD_PRESCALER  8'h00
`define RST_SERIAL_CONTROL  8'h00
// timing counts, in receiver samples, bit times or rate divider outputs
`define RT_PER_BIT          4'hf
`define RT_MID_BIT          4'h7
`define RT_PER_QUARTER      2'h3
`define BRK_DET_LIN_8       4'hd
`define BRK_DET_LIN_9       4'he
`define BRK_GEN_NORM_8      4'ha
`define BRK_GEN_NORM_9      4'hb
`define BRK_GEN_LIN_8       4'hd
`define BRK_GEN_LIN_9       4'he
`define BRK_GEN_BOTH_8      4'hb
`define BRK_GEN_BOTH_9      4'hc
`define IDLE_RT_8           8'ha0
`define IDLE_RT_9           8'hb0
// axi responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2
`endif

// File: design/serial_break_and_baud_control_pkg.sv
package serial_break_and_baud_control_pkg;
  typedef enum logic [4:0] {
    RX_IDLE  = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA  = 5'b00100,
    RX_STOP  = 5'b01000,
    RX_BRK   = 5'b10000
  } rx_state_e;
  typedef enum logic [2:0] {
    TX_IDLE  = 3'b001,
    TX_SHIFT = 3'b010,
    TX_BRK   = 3'b100
  } tx_state_e;
endpackage

// File: dv/bus_chk.sv
`timescale 1ns/10ps
module bus_chk
(
  // bus handshake seen at the block's ports
  input wire logic        clk_sys_i,
  input wire logic        reset_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic [7:0]  s_axi_araddr_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0]  s_axi_rresp_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i
);
  // ----------------------------------------
  // answer timing and register contents
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  sequence s_rd; s_axi_arvalid_i && s_axi_arready_o; endsequence
  property p_wans; s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_bvalid_o |=> s_axi_bvalid_o; endproperty
  a_wans: assert property (p_wans) else $error("write not answered");
  property p_bhold; s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o; endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_bdrop; s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o; endproperty
  a_bdrop: assert property (p_bdrop) else $error("write answer repeated");
  property p_rans; s_rd |=> s_axi_rvalid_o; endproperty
  a_rans: assert property (p_rans) else $error("read not answered");
  property p_rhold; s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o); endproperty
  a_rhold: assert property (p_rhold) else $error("read data moved");
  property p_byte; s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0; endproperty
  a_byte: assert property (p_byte) else $error("upper read bits set");
  property p_unmap; s_rd ##0 s_axi_araddr_i == 8'h04 |=> s_axi_rresp_o == 2'h2 && s_axi_rdata_o == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read accepted");
  property p_st2; s_rd ##0 s_axi_araddr_i == 8'h14 |=> s_axi_rdata_o[7:2] == 6'h0; endproperty
  a_st2: assert property (p_st2) else $error("status two spare bits set");
endmodule

// File: dv/line_partner.sv
`timescale 1ns/10ps
module line_partner
(
  // clock and serial line
  input  wire logic clk_sys_i,
  input  wire logic txd_i,
  output logic      rxd_o
);
  // ----------------------------------------
  // remote node, 64 clocks a bit
  // ----------------------------------------
  logic [7:0] got;
  initial rxd_o = 1'h1;
  // frames lsb first; the line returns to its idle one afterwards
  task automatic send(input logic [15:0] v, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_sys_i);
      rxd_o <= v[i];
      repeat (63) @(posedge clk_sys_i);
    end
    @(posedge clk_sys_i);
    rxd_o <= 1'h1;
  endtask
  // sample mid-bit, far from edges, so small skew is harmless
  always
  begin
    @(negedge txd_i);
    repeat (96) @(posedge clk_sys_i);
    for (int i = 0; i < 8; i++)
    begin
      got[i] = txd_i;
      repeat (64) @(posedge clk_sys_i);
    end
  end
endmodule

// File: dv/testbench.sv
`timescale 1ns/10ps
module testbench;
  // ----------------------------------------
  // stimulus, scenarios and verdict
  // ----------------------------------------
  logic clk_sys_i = 1'h0, reset_i = 1'h1, rxd_i, txd_o;
  logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
  logic s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0, s_axi_awready_o, s_axi_wready_o;
  logic s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, d;
  logic [3:0] s_axi_wstrb_i = 4'hf;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, r;
  int bad_count = 0;
  int total_checks = 0;
  serial_break_and_baud_control dut (.*);
  line_partner far (.clk_sys_i(clk_sys_i), .txd_i(txd_o), .rxd_o(rxd_i));
  always #12.5 clk_sys_i = ~clk_sys_i;
  // ready is looked at mid-cycle, so the taking edge is the next rising one
  task automatic wr(input logic [7:0] a, v);
    @(posedge clk_sys_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= {24'h0, v};
    s_axi_awvalid_i <= 1'h1;
    s_axi_wvalid_i <= 1'h1;
    s_axi_bready_i <= 1'h1;
    do @(negedge clk_sys_i); while (!s_axi_awready_o);
    @(posedge clk_sys_i);
    s_axi_awvalid_i <= 1'h0;
    s_axi_wvalid_i <= 1'h0;
    do @(negedge clk_sys_i); while (!s_axi_bvalid_o);
    @(posedge clk_sys_i);
    s_axi_bready_i <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'h1;
    s_axi_rready_i <= 1'h1;
    do @(negedge clk_sys_i); while (!s_axi_arready_o);
    @(posedge clk_sys_i);
    s_axi_arvalid_i <= 1'h0;
    do @(negedge clk_sys_i); while (!s_axi_rvalid_o);
    d = s_axi_rdata_o;
    r = s_axi_rresp_o;
    @(posedge clk_sys_i);
    s_axi_rready_i <= 1'h0;
  endtask
  task automatic chk(input string n, input logic [31:0] e, s);
    total_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("ERROR %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic rc(input logic [7:0] a, m, e);
    rd(a);
    chk($sformatf("reg %h", a), {24'h0, e}, d & {24'h0, m});
  endtask
  task automatic bits(input int n);
    repeat (n * 64) @(posedge clk_sys_i);
  endtask
  task automatic summarize();
    if (bad_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic t_reset();
    rc(8'h1c, 8'hff, 8'h00);
    rc(8'h20, 8'hff, 8'h00);
    rc(8'h14, 8'hff, 8'h00);
    rd(8'h04);
    chk("unmapped resp", 32'h2, {30'h0, r});
  endtask
  // prescaler code is left at its reset value, bypass, before enable and never written later
  task automatic t_rx();
    wr(8'h24, 8'h01);
    fork
      far.send({7'h7f, 8'ha5, 1'h0}, 10);
      begin
        bits(3);
        rc(8'h14, 8'h01, 8'h01);
      end
    join
    bits(12);
    rc(8'h14, 8'hff, 8'h00);
    rc(8'h10, 8'he2, 8'ha0);
    rc(8'h18, 8'hff, 8'ha5);
    reset_i <= 1'h1;
    bits(1);
    reset_i <= 1'h0;
    rc(8'h18, 8'hff, 8'ha5);
    wr(8'h24, 8'h01);
  endtask
  // the line is still low after the break, so a new start search has begun
  task automatic t_brk();
    far.send(16'h0000, 10);
    rc(8'h14, 8'hff, 8'h03);
    rc(8'h10, 8'hff, 8'ha2);
    rc(8'h18, 8'hff, 8'h00);
    bits(24);
    rc(8'h14, 8'hff, 8'h00);
  endtask
  task automatic t_tx();
    wr(8'h18, 8'h3c);
    bits(12);
    chk("line byte", 32'h3c, {24'h0, far.got});
    wr(8'h24, 8'h05);
    bits(2);
    wr(8'h24, 8'h01);
    bits(12);
    chk("line break", 32'h0, {24'h0, far.got});
  endtask
  // twelve zeros stay under the lengthened threshold, fourteen reach it
  task automatic t_lin();
    wr(8'h1c, 8'h20);
    rc(8'h1c, 8'hff, 8'h20);
    far.send(16'h0000, 12);
    bits(12);
    rc(8'h14, 8'hff, 8'h00);
    far.send(16'h0000, 14);
    bits(20);
    rc(8'h14, 8'hff, 8'h02);
  endtask
  // a hang is cut short here
  initial
  begin
    #1000000;
    bad_count++;
    summarize();
  end
  // main sequence
  initial
  begin
    repeat (4) @(posedge clk_sys_i);
    reset_i <= 1'h0;
    t_reset();
    t_rx();
    t_brk();
    t_tx();
    t_lin();
    summarize();
  end
endmodule
bind serial_break_and_baud_control bus_chk chk_u (.*);
